// *** rtl/nvs_seq.sv ***
// sequencer for sram to nonvolatile save and recall, with the store-request/busy pin
`timescale 1ns/100ps
module nvs_seq
  import nvs_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int STORE_CYCLES = STORE_CYC
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supplyOk,
  input wire logic cmdSave,
  input wire logic cmdRecall,
  input wire logic cmdAutoOn,
  input wire logic cmdAutoOff,
  input wire logic sramWrite,
  input wire logic storeReqIn,
  output logic storeReqOut,
  output logic storeReqOe_n,
  output logic accessEnable,
  output logic writeEnable,
  output logic ioLockout,
  output logic saveActive,
  output logic recallActive,
  output logic autoSaveOn,
  output logic modified
);
  nvs_state_t state;
  nvs_state_t next_state;
  nvs_kind_t kind;
  logic next_modified;
  logic saveDone;
  logic recallDone;
  logic softDone;

  nvs_tmr_if #(.W(CNT_W)) tmr ();

  nvs_timer u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .t(tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state and timer loads; every timed phase loads on entry
  always_comb
  begin
    next_state = state;
    tmr.load = 1'b0;
    tmr.count = '0;
    case (state)
      S_DOWN:
      begin
        if (supplyOk)
        begin
          next_state = S_PUREC;
          tmr.load = 1'b1;
          tmr.count = CNT_W'(PWRUP_CYCLES);
        end
      end
      S_PUREC:
      begin
        if (!supplyOk)
          next_state = S_DOWN;
        else if (tmr.done)
        begin
          next_state = S_PUSH;
          tmr.load = 1'b1;
          tmr.count = CNT_W'(HIGH_CYC);
        end
      end
      S_IDLE:
      begin
        if (!supplyOk)
        begin
          // power loss: save only if armed and something was written
          if (autoSaveOn && modified)
          begin
            next_state = S_GRACE;
            tmr.load = 1'b1;
            tmr.count = CNT_W'(GRACE_CYC);
          end
          else
            next_state = S_DOWN;
        end
        else if (!storeReqIn)
        begin
          // one sampled low cycle is enough to register a request
          if (modified)
          begin
            next_state = S_GRACE;
            tmr.load = 1'b1;
            tmr.count = CNT_W'(GRACE_CYC);
          end
          else
            next_state = S_RESUME;
        end
        else if (cmdSave || cmdRecall || cmdAutoOn || cmdAutoOff)
        begin
          next_state = S_SOFT;
          tmr.load = 1'b1;
          tmr.count = CNT_W'(SOFT_CYC);
        end
      end
      S_SOFT:
      begin
        // a command needs the supply to stay up to take effect
        if (!supplyOk)
          next_state = S_DOWN;
        else if (tmr.done)
        begin
          case (kind)
            K_SAVE:
            begin
              next_state = S_SAVE;
              tmr.load = 1'b1;
              tmr.count = CNT_W'(STORE_CYCLES);
            end
            K_RECALL:
            begin
              next_state = S_RECALL;
              tmr.load = 1'b1;
              tmr.count = CNT_W'(RECALL_CYC);
            end
            default:
              next_state = S_IDLE;
          endcase
        end
      end
      S_GRACE:
      begin
        if (tmr.done)
        begin
          next_state = S_SAVE;
          tmr.load = 1'b1;
          tmr.count = CNT_W'(STORE_CYCLES);
        end
      end
      S_SAVE:
      begin
        // a save runs to the end even on falling supply (held up by the capacitor)
        if (tmr.done)
        begin
          if (supplyOk)
          begin
            next_state = S_PUSH;
            tmr.load = 1'b1;
            tmr.count = CNT_W'(HIGH_CYC);
          end
          else
            next_state = S_DOWN;
        end
      end
      S_RECALL:
      begin
        if (!supplyOk)
          next_state = S_DOWN;
        else if (tmr.done)
        begin
          next_state = S_PUSH;
          tmr.load = 1'b1;
          tmr.count = CNT_W'(HIGH_CYC);
        end
      end
      S_PUSH:
      begin
        if (tmr.done)
          next_state = S_RESUME;
      end
      S_RESUME:
      begin
        if (!supplyOk)
          next_state = S_DOWN;
        else if (storeReqIn)
          next_state = S_IDLE;
      end
      default:
        next_state = S_DOWN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset waits for the supply as on a cold start
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      state <= S_DOWN;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command kind, latched as the soft sequence starts; save has priority
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      kind <= K_SAVE;
    else if (state == S_IDLE && next_state == S_SOFT)
    begin
      if (cmdSave)
        kind <= K_SAVE;
      else if (cmdRecall)
        kind <= K_RECALL;
      else if (cmdAutoOn)
        kind <= K_AUTO_ON;
      else
        kind <= K_AUTO_OFF;
    end
  end

  // automatic save enable, changed only when its soft sequence completes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      autoSaveOn <= AUTO_SAVE_RST;
    else if (softDone && kind == K_AUTO_ON)
      autoSaveOn <= 1'b1;
    else if (softDone && kind == K_AUTO_OFF)
      autoSaveOn <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion events of the timed phases
  assign saveDone = (state == S_SAVE) && tmr.done;
  assign recallDone = (state == S_PUREC || state == S_RECALL) && tmr.done;
  assign softDone = (state == S_SOFT) && tmr.done && supplyOk;

  // a write landing on the completion cycle keeps the flag set, so it is not lost
  always_comb
  begin
    next_modified = modified;
    if (saveDone || recallDone)
      next_modified = 1'b0;
    if (sramWrite && writeEnable)
      next_modified = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      modified <= 1'b0;
    else
      modified <= next_modified;
  end

  ////////////////////////////////////////////////////////////////////////////
  // access gating; only idle with good supply and released pin lets traffic in
  assign accessEnable = (state == S_IDLE) && supplyOk && storeReqIn;
  // grace phase lets a write already under way finish
  assign writeEnable = accessEnable || (state == S_GRACE);
  assign ioLockout = !accessEnable;
  assign saveActive = (state == S_SAVE);
  assign recallActive = (state == S_PUREC) || (state == S_RECALL);

  ////////////////////////////////////////////////////////////////////////////
  // pin driver: low as busy during cycles, briefly high after, else released
  always_comb
  begin
    storeReqOut = 1'b1;
    storeReqOe_n = 1'b1;
    case (state)
      S_SAVE, S_RECALL, S_PUREC:
      begin
        storeReqOut = 1'b0;
        storeReqOe_n = 1'b0;
      end
      S_PUSH:
      begin
        storeReqOut = 1'b1;
        storeReqOe_n = 1'b0;
      end
      default:
      begin
        storeReqOut = 1'b1;
        storeReqOe_n = 1'b1;
      end
    endcase
  end
endmodule // nvs_seq

// *** rtl/nvs_pkg.sv ***
// package of timing counts, state codes and command kinds for the store/recall sequencer
package nvs_pkg;
  // clock rate in MHz; counts below convert printed times to cycles
  localparam int CLK_MHZ = 10;
  localparam int CNT_W = 18;
  // printed times, in their own unit
  localparam int POWERUP_RECALL_TIME_MS = 20;
  localparam int STORE_CYCLE_TIME_MS = 8;
  localparam int WRITE_GRACE_TIME_NS = 25;
  localparam int SAVE_REQUEST_PULSE_MIN_NS = 15;
  localparam int SOFT_SEQUENCE_TIME_US = 100;
  localparam int RECALL_CYCLE_TIME_US = 200;
  localparam int PIN_HIGH_DRIVE_TIME_NS = 500;
  // longest times round down, least times round up, never below one cycle
  localparam int PWRUP_CYC = POWERUP_RECALL_TIME_MS * 1000 * CLK_MHZ * 1000 / 1000;
  localparam int STORE_CYC = STORE_CYCLE_TIME_MS * 1000 * CLK_MHZ;
  localparam int GRACE_RAW = WRITE_GRACE_TIME_NS * CLK_MHZ / 1000;
  localparam int GRACE_CYC = (GRACE_RAW < 1) ? 1 : GRACE_RAW;
  localparam int PULSE_RAW = (SAVE_REQUEST_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MIN_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
  localparam int SOFT_CYC = SOFT_SEQUENCE_TIME_US * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_CYCLE_TIME_US * CLK_MHZ;
  localparam int HIGH_RAW = PIN_HIGH_DRIVE_TIME_NS * CLK_MHZ / 1000;
  localparam int HIGH_CYC = (HIGH_RAW < 1) ? 1 : HIGH_RAW;
  // automatic save is armed after reset
  localparam logic AUTO_SAVE_RST = 1'b1;

  // gray codes along the power-up, idle, save, push-high, resume path
  typedef enum logic [3:0] {
    S_DOWN = 4'h0,
    S_PUREC = 4'h1,
    S_IDLE = 4'h3,
    S_SOFT = 4'h2,
    S_GRACE = 4'h6,
    S_SAVE = 4'h7,
    S_PUSH = 4'h5,
    S_RESUME = 4'h4,
    S_RECALL = 4'hc
  } nvs_state_t;

  typedef enum logic [1:0] {
    K_SAVE = 2'h0,
    K_RECALL = 2'h1,
    K_AUTO_ON = 2'h2,
    K_AUTO_OFF = 2'h3
  } nvs_kind_t;
endpackage

// *** rtl/nvs_tmr_if.sv ***
// interface between the sequencer and its cycle timer
`timescale 1ns/100ps
interface nvs_tmr_if #(parameter int W = nvs_pkg::CNT_W);
  logic load;
  logic [W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// *** rtl/nvs_timer.sv ***
// down-counting cycle timer used for every timed phase
`timescale 1ns/100ps
module nvs_timer
  import nvs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  nvs_tmr_if.tmr t
);
  logic [CNT_W-1:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // a load of n makes done rise n-1 edges later, so the phase lasts n cycles
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cnt <= '0;
    else if (t.load)
      cnt <= t.count;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  // done must not look at load: the sequencer loads on done, which would close a zero-delay loop
  assign t.done = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // nvs_timer

// *** test/nvs_seq_sva.sv ***
// port-level checker for the store/recall sequencer
`timescale 1ns/100ps
module nvs_seq_sva
  import nvs_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYC
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supplyOk,
  input wire logic sramWrite,
  input wire logic storeReqIn,
  input wire logic storeReqOut,
  input wire logic storeReqOe_n,
  input wire logic accessEnable,
  input wire logic writeEnable,
  input wire logic ioLockout,
  input wire logic saveActive,
  input wire logic recallActive,
  input wire logic modified
);
  int saveRun;
  int pushRun;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // run lengths; a stuck phase shows as a count past its bound
  always_ff @(posedge mclk)
  begin
    saveRun <= (!reset_n || !saveActive) ? 0 : saveRun + 1;
  end
  // high push on the pin, counted while we drive it high
  always_ff @(posedge mclk)
  begin
    pushRun <= (!reset_n || storeReqOe_n || !storeReqOut) ? 0 : pushRun + 1;
  end
  sequence s_grace;
    writeEnable && !accessEnable;
  endsequence
  sequence s_saving;
    saveActive && !storeReqOe_n && !storeReqOut;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_lock_mirror: assert property (ioLockout == !accessEnable)
    else $error("lockout is not the inverse of access");
  a_grace_save: assert property (s_grace |=> s_saving)
    else $error("grace cycle not followed by save");
  a_save_bound: assert property (saveRun <= STORE_CYCLES)
    else $error("save phase too long");
  a_push_bound: assert property (pushRun <= HIGH_CYC)
    else $error("pin driven high too long");
  a_busy_blocks: assert property (saveActive || recallActive |-> !accessEnable)
    else $error("access open during a cycle");
  a_supply_blocks: assert property (!supplyOk |-> !accessEnable)
    else $error("access open at low supply");
  a_pin_blocks: assert property (!storeReqIn |-> !accessEnable)
    else $error("access open while pin low");
  a_clean_skip: assert property (!storeReqIn && $past(accessEnable) && !modified
    |=> storeReqOe_n && !saveActive)
    else $error("clean request not skipped");
  a_resume_quick: assert property ($rose(storeReqOe_n) && storeReqIn && supplyOk
    |-> ##[0:50] (accessEnable || !supplyOk))
    else $error("access not resumed in time");
  a_write_marks: assert property (sramWrite && writeEnable |=> modified)
    else $error("write did not mark modified");
endmodule // nvs_seq_sva
bind nvs_seq nvs_seq_sva #(.STORE_CYCLES(STORE_CYCLES)) chk_i (.mclk(mclk),
  .reset_n(reset_n), .supplyOk(supplyOk), .sramWrite(sramWrite),
  .storeReqIn(storeReqIn), .storeReqOut(storeReqOut), .storeReqOe_n(storeReqOe_n),
  .accessEnable(accessEnable), .writeEnable(writeEnable), .ioLockout(ioLockout),
  .saveActive(saveActive), .recallActive(recallActive), .modified(modified));

// *** test/nvs_host_model.sv ***
// host model: pulls the store-request pin low and resolves the wire
`timescale 1ns/100ps
module nvs_host_model
#(
  parameter int HOLD = 2
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic storeReqOut,
  input wire logic storeReqOe_n,
  output logic pinLevel
);
  int left;
  // low hold of HOLD cycles, above the one-cycle minimum
  always_ff @(posedge mclk)
  begin
    left <= !reset_n ? 0 : (start ? HOLD : (left > 0 ? left - 1 : 0));
  end
  // device drive wins; released pin rests on the pull-up
  assign pinLevel = !storeReqOe_n ? storeReqOut : (left == 0);
endmodule // nvs_host_model

// *** test/nv_store_recall_sequencer_bench.sv ***
// bench for the store/recall sequencer with a host pin model
`timescale 1ns/100ps
module nv_store_recall_sequencer_bench;
  import nvs_pkg::*;
  localparam int PW = 20;
  localparam int ST = 10;
  localparam int SB = SOFT_CYC + RECALL_CYC + HIGH_CYC + 3;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic supplyOk = 1'b1;
  logic [5:0] strb = 6'h00;
  logic pinLevel, storeReqOut, storeReqOe_n, accessEnable, writeEnable;
  logic ioLockout, saveActive, recallActive, autoSaveOn, modified;
  int failures = 0;
  int compares = 0;
  int n, sv, rc;
  always #50 mclk = ~mclk;
  // strobes: 0 save, 1 recall, 2 auto on, 3 auto off, 4 write, 5 pin request
  nvs_seq #(.PWRUP_CYCLES(PW), .STORE_CYCLES(ST)) uut (.mclk(mclk), .reset_n(reset_n),
    .supplyOk(supplyOk), .cmdSave(strb[0]), .cmdRecall(strb[1]), .cmdAutoOn(strb[2]),
    .cmdAutoOff(strb[3]), .sramWrite(strb[4]), .storeReqIn(pinLevel),
    .storeReqOut(storeReqOut), .storeReqOe_n(storeReqOe_n), .accessEnable(accessEnable),
    .writeEnable(writeEnable), .ioLockout(ioLockout), .saveActive(saveActive),
    .recallActive(recallActive), .autoSaveOn(autoSaveOn), .modified(modified));
  nvs_host_model #(.HOLD(2)) host (.mclk(mclk), .reset_n(reset_n), .start(strb[5]),
    .storeReqOut(storeReqOut), .storeReqOe_n(storeReqOe_n), .pinLevel(pinLevel));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // one-cycle strobe; returns at the edge that takes it
  task pulse(input int k);
    @(posedge mclk);
    strb[k] <= 1'b1;
    @(posedge mclk);
    strb[k] <= 1'b0;
  endtask
  task supply(input logic v);
    @(posedge mclk);
    supplyOk <= v;
  endtask
  // waits for access, counting busy cycles; limit hit leaves accessEnable low
  task wait_ae(input int lim);
    n = 0;
    sv = 0;
    rc = 0;
    @(negedge mclk);
    while (accessEnable !== 1'b1 && n < lim)
    begin
      n++;
      sv += (saveActive === 1'b1);
      rc += (recallActive === 1'b1);
      @(negedge mclk);
    end
  endtask
  task t_power_up;
    chk("modified", 0, modified);
    chk("autoSaveOn", 1, autoSaveOn);
    wait_ae(100);
    chk("recall cycles", PW, rc);
    chk("access", 1, accessEnable);
    $display("power_up done");
  endtask
  task t_pin(input logic dirty);
    if (dirty)
      pulse(4);
    #1 chk("modified", dirty, modified);
    pulse(5);
    wait_ae(200);
    chk("save cycles", dirty ? ST : 0, sv);
    chk("modified", 0, modified);
    chk("access", 1, accessEnable);
    $display("pin request done");
  endtask
  task t_soft(input int k, input int expRc, input int expSv);
    pulse(4);
    pulse(k);
    #1 chk("ioLockout", 1, ioLockout);
    wait_ae(SB + 10);
    chk("recall cycles", expRc, rc);
    chk("save cycles", expSv, sv);
    chk("soft bound", 1, n <= SB);
    chk("modified", 0, modified);
    $display("soft command done");
  endtask
  task t_auto;
    pulse(3);
    wait_ae(SB);
    chk("autoSaveOn", 0, autoSaveOn);
    pulse(4);
    supply(1'b0);
    wait_ae(40);
    chk("save cycles", 0, sv);
    chk("access", 0, accessEnable);
    supply(1'b1);
    wait_ae(100);
    chk("modified", 0, modified);
    pulse(2);
    wait_ae(SB);
    chk("autoSaveOn", 1, autoSaveOn);
    pulse(4);
    supply(1'b0);
    wait_ae(40);
    chk("save cycles", ST, sv);
    supply(1'b1);
    wait_ae(100);
    chk("access", 1, accessEnable);
    $display("auto save done");
  endtask
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog well past the roughly 6200 cycles the tests take
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_power_up();
    t_pin(1'b0);
    t_pin(1'b1);
    t_soft(1, RECALL_CYC, 0);
    t_soft(0, 0, ST);
    t_auto();
    close_out();
  end
endmodule // nv_store_recall_sequencer_bench
